/* core/swc_ctl.sv */
// System reset, wait state, chip select and misc control logic
`timescale 1ns/10ps
`default_nettype none
module swc_ctl #(
    parameter int POR_CYCLES = swc_pkg::POR_CYCLES_DEF
) (
    input  wire logic               clk_in,
    input  wire logic               reset_in,
    input  wire swc_pkg::swc_bus_type bus_in,
    output logic [7:0]              rdata_out,
    output logic                    rdata_valid_out,
    input  wire logic               ext_reset_n_in,
    output logic                    reset_pin_out,
    output logic                    reset_pin_oe_out,
    input  wire logic               ext_wait_n_in,
    output logic                    cpu_wait_n_out,
    output logic                    wait_pin_out,
    output logic                    wait_pin_oe_out,
    input  wire logic               evaluation_mode_pin_in,
    output logic                    cpu_disconnect_out,
    output logic                    bus_drive_enable_out,
    output logic                    lower_region_select_n_out,
    output logic                    upper_region_select_n_out,
    input  wire logic               ext_clock_source_in,
    output logic                    clock_div_bypass_out,
    output logic                    crc32_select_out
);
    import swc_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // On-chip peripheral I/O map, no programmed waits for these
    function automatic logic is_onchip(input logic [7:0] a);
        return (a[7:2] == 6'h04) || (a[7:3] == 5'h03) ||
               (a == 8'hF0) || (a == 8'hF1) || (a == 8'hF4) ||
               (a == IO_INDEX_POINTER) || (a == IO_DATA_PORT);
    endfunction : is_onchip

    // Two-bit code to 0, 2, 4 or 6 waits
    function automatic logic [3:0] twice(input logic [1:0] c);
        return {1'b0, c, 1'b0};
    endfunction : twice

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [19:0] por_cnt;
    logic        por_active;
    logic [4:0]  ext_cnt;
    logic        ext_prev_n;
    logic [7:0]  index_ptr;
    logic [7:0]  wait_ctrl;
    logic [7:0]  mem_wait_bnd;
    logic [7:0]  cs_boundary;
    logic [7:0]  misc_control;
    logic        eval_mode;
    logic        mem_prev_n;
    logic        io_prev_n;
    logic        m1_prev_n;
    logic        wr_prev;
    logic [3:0]  wait_cnt;
    logic        ed_seen;
    logic        interrupt_return_instruction_pend;
    logic [7:0]  last_op;
    logic [3:0]  next_wait;

    wire logic [3:0] nib      = bus_in.addr[15:12];
    wire logic       io_act   = !bus_in.io_request_strobe_n;
    wire logic       m1_act   = !bus_in.opcode_fetch_strobe_n;
    wire logic       mem_start = !bus_in.mem_req_n && mem_prev_n;
    wire logic       io_start  = io_act && io_prev_n;
    wire logic       ext_fall  = ext_prev_n && !ext_reset_n_in;
    wire logic       int_wait  = (wait_cnt != 4'h0);
    wire logic       io_wr     = io_act && !bus_in.wr_n && !m1_act;
    wire logic       wr_start  = io_wr && !wr_prev;
    wire logic [1:0] daisy     = wait_ctrl[WC_DAISY_LSB +: 2];

    // ----------------------------------------------------------------
    // Reset driver
    // ----------------------------------------------------------------
    // Power-on period counted from the supply detection reset
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            por_cnt    <= 20'h00000;
            por_active <= 1'b1;
        end else if (por_active) begin
            if (por_cnt == 20'(POR_CYCLES - 1)) begin
                por_active <= 1'b0;
            end
            por_cnt <= por_cnt + 20'h00001;
        end
    end

    // Extension only after power-up; own drive masks further falls
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ext_cnt    <= 5'h00;
            ext_prev_n <= 1'b1;
        end else begin
            ext_prev_n <= ext_reset_n_in;
            if (!por_active && ext_fall &&
                !misc_control[MC_RST_DIS]) begin
                ext_cnt <= 5'(RST_EXT_CLOCKS);
            end else if (ext_cnt != 5'h00) begin
                ext_cnt <= ext_cnt - 5'h01;
            end
        end
    end

    // Open drain: only ever drives low
    always_comb begin
        reset_pin_out    = 1'b0;
        reset_pin_oe_out = por_active || ((ext_cnt != 5'h00) &&
                           !misc_control[MC_RST_DIS]);
    end

    AST_POR_DRIVE: assert property (@(posedge clk_in)
        reset_in |=> reset_pin_oe_out && !reset_pin_out)
        else $error("reset pin not driven during power-on");
    AST_POR_RELEASE: assert property (@(posedge clk_in)
        disable iff (reset_in)
        $fell(por_active) && ext_cnt == 5'h00 |-> !reset_pin_oe_out)
        else $error("reset pin still driven after power-on");
    AST_EXT_16: assert property (@(posedge clk_in) disable iff (reset_in)
        !por_active && ext_fall && !misc_control[MC_RST_DIS] |=>
        reset_pin_oe_out[*8] ##1 reset_pin_oe_out[*8] ##1
        (!reset_pin_oe_out || ext_fall))
        else $error("reset extension is not 16 clocks");
    AST_RST_DISABLE: assert property (@(posedge clk_in)
        disable iff (reset_in)
        !por_active && misc_control[MC_RST_DIS] |-> !reset_pin_oe_out)
        else $error("reset driven while output disabled");

    // ----------------------------------------------------------------
    // Indirect register access
    // ----------------------------------------------------------------
    // Write taken once, on the first cycle of the strobe
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wr_prev      <= 1'b0;
            index_ptr    <= 8'h00;
            wait_ctrl    <= WAIT_CTRL_RST;
            mem_wait_bnd <= MEM_WAIT_RST;
            cs_boundary  <= CS_BND_RST;
            misc_control <= MISC_CTRL_RST;
        end else begin
            wr_prev <= io_wr;
            if (wr_start && bus_in.addr[7:0] == IO_INDEX_POINTER) begin
                index_ptr <= bus_in.data;
            end
            if (wr_start && bus_in.addr[7:0] == IO_DATA_PORT) begin
                unique case (index_ptr)
                    IDX_WAIT_CTRL:    wait_ctrl    <= bus_in.data;
                    IDX_MEM_WAIT_BND: mem_wait_bnd <= bus_in.data;
                    IDX_CS_BOUNDARY:  cs_boundary  <= bus_in.data;
                    IDX_MISC_CTRL:    misc_control <= bus_in.data;
                    default: ;
                endcase
            end
        end
    end

    // Read data; unknown index reads as zero
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
        end else if (bus_in.addr[7:0] == IO_INDEX_POINTER) begin
            rdata_out <= index_ptr;
        end else begin
            unique case (index_ptr)
                IDX_WAIT_CTRL:    rdata_out <= wait_ctrl;
                IDX_MEM_WAIT_BND: rdata_out <= mem_wait_bnd;
                IDX_CS_BOUNDARY:  rdata_out <= cs_boundary;
                IDX_MISC_CTRL:    rdata_out <= misc_control;
                default:          rdata_out <= 8'h00;
            endcase
        end
    end

    // Valid combinationally as soon as a read of either port stands, with no cycle of delay
    always_comb begin
        rdata_valid_out = io_act && !m1_act && !bus_in.rd_n &&
                          ((bus_in.addr[7:0] == IO_INDEX_POINTER) ||
                           (bus_in.addr[7:0] == IO_DATA_PORT));
    end

    AST_RESET_VALUES: assert property (@(posedge clk_in)
        reset_in |=> cs_boundary == 8'h0F && misc_control[MC_CS0_EN] &&
        !misc_control[MC_CS1_EN])
        else $error("wrong power-on select setup");

    // ----------------------------------------------------------------
    // Wait state generator
    // ----------------------------------------------------------------
    // Load on cycle start; interrupt acknowledge is I/O with fetch
    always_comb begin
        next_wait = 4'h0;
        if (mem_start && nib <= mem_wait_bnd[3:0]) begin
            next_wait = {2'b00, wait_ctrl[WC_MEM_LSB +: 2]};
        end
        if (mem_start && m1_act) begin
            next_wait = next_wait + {3'b000, wait_ctrl[WC_OPF_BIT]};
            if (ed_seen && daisy[1]) begin
                next_wait = next_wait + 4'h1;
            end
        end
        if (io_start && m1_act) begin
            next_wait = twice(daisy) +
                        {3'b000, wait_ctrl[WC_VEC_BIT]};
        end else if (io_start && !is_onchip(bus_in.addr[7:0])) begin
            next_wait = twice(wait_ctrl[WC_IO_LSB +: 2]);
        end
    end

    // Strobe history and return sequence tracking
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mem_prev_n <= 1'b1;
            io_prev_n  <= 1'b1;
            m1_prev_n  <= 1'b1;
            last_op    <= 8'h00;
            ed_seen    <= 1'b0;
        end else begin
            mem_prev_n <= bus_in.mem_req_n;
            io_prev_n  <= bus_in.io_request_strobe_n;
            m1_prev_n  <= bus_in.opcode_fetch_strobe_n;
            if (m1_act && !bus_in.mem_req_n && !bus_in.rd_n) begin
                last_op <= bus_in.data;
            end
            if (!m1_prev_n && !m1_act && bus_in.io_request_strobe_n) begin
                ed_seen <= ed_seen;
            end else if (!m1_prev_n && !m1_act) begin
                ed_seen <= 1'b0;
            end else if (!m1_prev_n && m1_act == 1'b0) begin
                ed_seen <= ed_seen;
            end
            if (!m1_prev_n && !m1_act == 1'b0) begin
                ed_seen <= (last_op == OP_PREFIX_ED);
            end
        end
    end

    // Down counter; a 4Dh second byte stretches to two or four waits
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wait_cnt  <= 4'h0;
            interrupt_return_instruction_pend <= 1'b0;
        end else if (mem_start || io_start) begin
            wait_cnt  <= next_wait;
            interrupt_return_instruction_pend <= mem_start && m1_act && ed_seen && daisy[1];
        end else begin
            // Second byte looked at once only, so no stale extension
            interrupt_return_instruction_pend <= 1'b0;
            if (interrupt_return_instruction_pend && bus_in.data == OP_RETURN_4D) begin
                // One or three more, less the wait spent in this cycle
                wait_cnt <= wait_cnt + (daisy[0] ? 4'h2 : 4'h0);
            end else if (int_wait) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end

    // External wait looked at only once the count is spent
    always_comb begin
        cpu_wait_n_out  = int_wait ? 1'b0 : ext_wait_n_in;
        wait_pin_out    = !int_wait;
        wait_pin_oe_out = eval_mode;
    end

    AST_CPU_WAIT: assert property (@(posedge clk_in) disable iff (reset_in)
        (int_wait || !ext_wait_n_in) |-> !cpu_wait_n_out)
        else $error("wait request not the OR of both sources");
    AST_IO_ONCHIP: assert property (@(posedge clk_in)
        disable iff (reset_in)
        io_start && !m1_act && is_onchip(bus_in.addr[7:0]) |=>
        !int_wait)
        else $error("programmed wait on on-chip I/O");
    AST_IO_WAITS: assert property (@(posedge clk_in) disable iff (reset_in)
        io_start && !m1_act && !is_onchip(bus_in.addr[7:0]) &&
        wait_ctrl[WC_IO_LSB +: 2] == 2'b01 |=>
        int_wait[*2] ##1 !int_wait)
        else $error("I/O code 1 did not give two waits");
    AST_MEM_RANGE: assert property (@(posedge clk_in)
        disable iff (reset_in)
        mem_start && !m1_act && nib > mem_wait_bnd[3:0] |=> !int_wait)
        else $error("memory wait outside boundary");

    // ----------------------------------------------------------------
    // Chip selects, misc bits, evaluation mode
    // ----------------------------------------------------------------
    // Address nibble only; registered on the clock, so glitches on address are not passed through
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            lower_region_select_n_out <= 1'b1;
            upper_region_select_n_out <= 1'b1;
        end else begin
            lower_region_select_n_out <= !(misc_control[MC_CS0_EN] &&
                nib <= cs_boundary[3:0]);
            upper_region_select_n_out <= !(misc_control[MC_CS1_EN] &&
                nib <= cs_boundary[7:4] &&
                nib > cs_boundary[3:0]);
        end
    end

    AST_CS0: assert property (@(posedge clk_in) disable iff (reset_in)
        ##1 $past(misc_control[MC_CS0_EN]) && $past(nib) == 4'h0 |->
        !lower_region_select_n_out)
        else $error("lower select missing at nibble zero");
    AST_CS1: assert property (@(posedge clk_in) disable iff (reset_in)
        ##1 $past(nib) <= $past(cs_boundary[3:0]) |->
        upper_region_select_n_out)
        else $error("upper select active in lower range");

    // Strap caught while power-on reset runs, held after
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            eval_mode <= 1'b0;
        end else if (por_active) begin
            eval_mode <= evaluation_mode_pin_in;
        end
    end

    always_comb begin
        cpu_disconnect_out   = eval_mode;
        bus_drive_enable_out = !eval_mode;
        clock_div_bypass_out = misc_control[MC_DIV1] &&
                               !ext_clock_source_in;
        crc32_select_out     = misc_control[MC_CRC32];
    end

    AST_EVAL_FLOAT: assert property (@(posedge clk_in)
        disable iff (reset_in)
        eval_mode |-> !bus_drive_enable_out && wait_pin_oe_out &&
        (wait_pin_out == cpu_wait_n_out || !ext_wait_n_in))
        else $error("evaluation mode outputs wrong");

endmodule : swc_ctl
`default_nettype wire

/* dv/swc_cpu_model.sv */
// Processor bus master model that drives the control block's bus
`timescale 1ns/10ps
`default_nettype none
module swc_cpu_model (
    input  wire logic                 clk_in,
    input  wire logic [7:0]           rdata_in,
    input  wire logic                 wait_n_in,
    output var  swc_pkg::swc_bus_type bus_out
);
    import swc_pkg::*;

    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    // Idle bus at start: all strobes inactive
    initial begin
        bus_out = {16'h0000, 8'h00, 5'h1F};
    end

    // One cycle held for a fixed number of edges; longer than any wait
    // count, so low wait samples in the window give the inserted waits
    task automatic cyc(input logic [15:0] a, input logic [7:0] d,
                       input logic [4:0] s, input int n,
                       output logic [7:0] q, output int w);
        w = 0;
        @(posedge clk_in);
        #1;
        bus_out = {a, d, s};
        repeat (n) begin
            @(posedge clk_in);
            #1;
            w += int'(wait_n_in === 1'b0);
        end
        q = rdata_in;
        // Released lines show the inverse, so stale values never match
        bus_out = {~a, ~d, 5'h1F};
    endtask : cyc

    // Indirect write: index to pointer port, then value to data port
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
        logic [7:0] q;
        int         w;
        cyc({8'h00, IO_INDEX_POINTER}, idx, 5'h16, 1, q, w);
        cyc({8'h00, IO_DATA_PORT}, val, 5'h16, 1, q, w);
    endtask : wr_reg

    // Indirect read through the same pointer and data port pair
    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] q);
        int w;
        cyc({8'h00, IO_INDEX_POINTER}, idx, 5'h16, 1, q, w);
        cyc({8'h00, IO_DATA_PORT}, 8'h00, 5'h15, 1, q, w);
    endtask : rd_reg
endmodule : swc_cpu_model
`default_nettype wire

/* dv/swc_ctl_test.sv */
// Self-checking bench for the system wait and chip select control
`timescale 1ns/10ps
`default_nettype none
module swc_ctl_test;
    import swc_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and wiring
    // ----------------------------------------------------------------
    localparam int         POR_N = 20;  // Short power-on period
    localparam logic [4:0] IOR   = 5'h15;
    localparam logic [4:0] MRD   = 5'h0D;
    localparam logic [4:0] FET   = 5'h09;
    localparam logic [4:0] ACK   = 5'h13;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        ext_src_n = 1'b1;
    logic        ext_wait_n = 1'b1;
    logic        eval = 1'b0;
    logic        ext_clk = 1'b0;
    swc_bus_type bus;
    logic [7:0]  rdata;
    logic        rst_out, rst_oe, cpu_wait_n, wait_pin, wait_oe, rvalid;
    logic        disc, bus_en, lower_n, upper_n, bypass, crc32;
    logic [7:0]  cur_wc = 8'h00;
    logic [7:0]  q;
    int          w, c;
    int          fail_count = 0;
    int          compares = 0;
    logic [7:0]  rst_val [5] = '{8'h00, 8'h00, 8'h0F, 8'h01, 8'h00};
    // Open-drain reset pin: low while the block drives it
    wire logic   rst_wire_n = rst_oe ? rst_out : ext_src_n;

    // Free-running system clock
    always #20 clk_in = ~clk_in;

    swc_ctl #(.POR_CYCLES(POR_N)) i_dut (
        .clk_in(clk_in), .reset_in(reset_in), .bus_in(bus),
        .rdata_out(rdata), .rdata_valid_out(rvalid),
        .ext_reset_n_in(rst_wire_n), .reset_pin_out(rst_out),
        .reset_pin_oe_out(rst_oe), .ext_wait_n_in(ext_wait_n),
        .cpu_wait_n_out(cpu_wait_n), .wait_pin_out(wait_pin),
        .wait_pin_oe_out(wait_oe), .evaluation_mode_pin_in(eval),
        .cpu_disconnect_out(disc), .bus_drive_enable_out(bus_en),
        .lower_region_select_n_out(lower_n),
        .upper_region_select_n_out(upper_n),
        .ext_clock_source_in(ext_clk), .clock_div_bypass_out(bypass),
        .crc32_select_out(crc32));

    // External CPU sees the wait pin in evaluation mode
    swc_cpu_model i_cpu (
        .clk_in(clk_in), .rdata_in(rdata),
        .wait_n_in(eval ? wait_pin : cpu_wait_n), .bus_out(bus));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic count_oe(input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(posedge clk_in);
            #1;
            cnt += int'(rst_oe === 1'b1);
        end
    endtask : count_oe

    task automatic do_reset(input logic ev);
        eval = ev;
        reset_in = 1'b1;
        repeat (6) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        // Pin is also driven in the cycle before the first counted edge
        w = int'(rst_oe === 1'b1);
        count_oe(40, c);
        check(c + w, POR_N);
        check({rst_oe, rst_wire_n}, 2'b01);
        cur_wc = 8'h00;
    endtask : do_reset

    // Wait control rewritten only on change, so fetch pairs stay adjacent
    task automatic wcase(input logic [7:0] wc, input logic [15:0] a,
                         input logic [7:0] d, input logic [4:0] s,
                         input int exp);
        if (wc !== cur_wc) i_cpu.wr_reg(IDX_WAIT_CTRL, wc);
        cur_wc = wc;
        i_cpu.cyc(a, d, s, 10, q, w);
        check(w, exp);
    endtask : wcase

    task automatic report_and_stop();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // Main test sequence
    initial begin
        do_reset(1'b0);
        check({disc, bus_en, wait_oe, bypass, crc32}, 5'h08);
        for (int i = 0; i < 5; i++) begin
            i_cpu.rd_reg(8'(i), q);
            check(q, rst_val[i]);
        end
        $display("test reset_values done");
        i_cpu.wr_reg(IDX_MISC_CTRL, 8'h14);
        i_cpu.rd_reg(IDX_MISC_CTRL, q);
        check(q, 8'h14);
        check({bypass, crc32}, 2'b11);
        // Data port read held two edges: valid only while the strobe stands
        fork
            i_cpu.cyc({8'h00, IO_DATA_PORT}, 8'h00, IOR, 2, q, w);
            begin
                @(posedge clk_in);
                #2;
                check(rvalid, 1'b1);
                repeat (2) @(posedge clk_in);
                #2;
                check(rvalid, 1'b0);
            end
        join
        check(q, 8'h14);
        ext_clk = 1'b1;
        #40;
        check(bypass, 1'b0);
        $display("test misc_control done");
        i_cpu.wr_reg(IDX_CS_BOUNDARY, 8'h73);
        i_cpu.wr_reg(IDX_MISC_CTRL, 8'h03);
        for (int n = 0; n < 16; n++) begin
            i_cpu.cyc({4'(n), 12'h000}, 8'h00, MRD, 1, q, w);
            check({lower_n, upper_n}, {n > 3, n <= 3 || n > 7});
        end
        i_cpu.wr_reg(IDX_MISC_CTRL, 8'h02);
        i_cpu.cyc(16'h0000, 8'h00, MRD, 1, q, w);
        check(lower_n, 1'b1);
        $display("test chip_selects done");
        i_cpu.wr_reg(IDX_MEM_WAIT_BND, 8'h05);
        wcase(8'h03, 16'h5000, 8'h00, MRD, 3);
        wcase(8'h03, 16'h6000, 8'h00, MRD, 0);
        wcase(8'h07, 16'h5000, 8'h00, FET, 4);
        for (int k = 0; k < 4; k++) begin
            wcase(8'(k << 3), 16'h0040, 8'h00, IOR, 2 * k);
            wcase(8'(k << 6) | 8'h20, 16'h0000, 8'h00, ACK, 2*k+1);
        end
        wcase(8'h40, 16'h0000, 8'h00, ACK, 2);
        wcase(8'h18, 16'h0010, 8'h00, IOR, 0);
        wcase(8'h18, 16'h00F4, 8'h00, IOR, 0);
        ext_wait_n = 1'b0;
        wcase(8'h08, 16'h0040, 8'h00, IOR, 10);
        ext_wait_n = 1'b1;
        wcase(8'h80, 16'h8000, OP_PREFIX_ED, FET, 0);
        wcase(8'h80, 16'h8001, OP_RETURN_4D, FET, 2);
        wcase(8'hC0, 16'h8000, OP_PREFIX_ED, FET, 0);
        wcase(8'hC0, 16'h8001, OP_RETURN_4D, FET, 4);
        wcase(8'hC0, 16'h8000, OP_PREFIX_ED, FET, 0);
        wcase(8'hC0, 16'h8001, 8'h00, FET, 1);
        wcase(8'h40, 16'h8000, OP_PREFIX_ED, FET, 0);
        wcase(8'h40, 16'h8001, OP_RETURN_4D, FET, 0);
        $display("test wait_states done");
        for (int b = 0; b < 2; b++) begin
            i_cpu.wr_reg(IDX_MISC_CTRL, b ? 8'h08 : 8'h00);
            ext_src_n = 1'b0;
            fork
                count_oe(24, c);
                begin
                    repeat (3) @(posedge clk_in);  // Held three clocks
                    #1;
                    ext_src_n = 1'b1;
                end
            join
            check(c, b ? 0 : RST_EXT_CLOCKS);
        end
        $display("test reset_extension done");
        do_reset(1'b1);
        check({disc, bus_en, wait_oe}, 3'b101);
        ext_wait_n = 1'b0;
        wcase(8'h08, 16'h0040, 8'h00, IOR, 2);
        $display("test evaluation_mode done");
        report_and_stop();
    end

    // Watchdog well beyond the expected run of a few hundred cycles
    initial begin
        #400000;
        fail_count++;
        report_and_stop();
    end
endmodule : swc_ctl_test
`default_nettype wire

/* inc/swc_pkg.sv */
// Constants and carrier types for the system wait and chip select control
package swc_pkg;

    // ----------------------------------------------------------------
    // I/O ports and indirect register indices
    // ----------------------------------------------------------------
    localparam logic [7:0] IO_INDEX_POINTER = 8'hEE;
    localparam logic [7:0] IO_DATA_PORT     = 8'hEF;
    localparam logic [7:0] IDX_WAIT_CTRL    = 8'h00;
    localparam logic [7:0] IDX_MEM_WAIT_BND = 8'h01;
    localparam logic [7:0] IDX_CS_BOUNDARY  = 8'h02;
    localparam logic [7:0] IDX_MISC_CTRL    = 8'h03;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int WC_MEM_LSB   = 0;  // Two bits, 0..3 memory waits
    localparam int WC_OPF_BIT   = 2;  // Extra opcode fetch wait
    localparam int WC_IO_LSB    = 3;  // Two bits, code times two waits
    localparam int WC_VEC_BIT   = 5;  // Interrupt vector wait
    localparam int WC_DAISY_LSB = 6;  // Two bits, code times two waits
    localparam int MC_CS0_EN    = 0;
    localparam int MC_CS1_EN    = 1;
    localparam int MC_CRC32     = 2;
    localparam int MC_RST_DIS   = 3;
    localparam int MC_DIV1      = 4;

    // ----------------------------------------------------------------
    // Reset values and opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] WAIT_CTRL_RST  = 8'h00;
    localparam logic [7:0] MEM_WAIT_RST   = 8'h00;
    localparam logic [7:0] CS_BND_RST     = 8'h0F;
    localparam logic [7:0] MISC_CTRL_RST  = 8'h01;
    localparam logic [7:0] OP_PREFIX_ED   = 8'hED;
    localparam logic [7:0] OP_RETURN_4D   = 8'h4D;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ         = 25_000_000;
    localparam int POR_TIME_MS    = 25;
    localparam int POR_CYCLES_DEF = POR_TIME_MS * (CLK_HZ / 1000);
    localparam int RST_EXT_CLOCKS = 16;

    // Processor bus as seen by the block
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        mem_req_n;
        logic        io_request_strobe_n;
        logic        opcode_fetch_strobe_n;
        logic        rd_n;
        logic        wr_n;
    } swc_bus_type;

endpackage : swc_pkg
